// file: hw/vpc_pkg.sv
// vpc_pkg: constants and types of the parameter group payload codec
// assumes a single 10 MHz system clock; no tool or bus dependencies
package vpc_pkg;

    // ==========================================================
    // clock and repetition timing
    localparam int unsigned CLK_HZ         = 10_000_000;   // system clock rate
    localparam int unsigned MS_PER_S       = 1000;         // unit conversion
    localparam int unsigned WBP_PERIOD_MS  = 100;          // wheel pressure repeat
    localparam int unsigned SUP_PERIOD_MS  = 1000;         // supply pressure repeat
    localparam int unsigned WBP_PERIOD_CYC = CLK_HZ / MS_PER_S * WBP_PERIOD_MS;
    localparam int unsigned SUP_PERIOD_CYC = CLK_HZ / MS_PER_S * SUP_PERIOD_MS;

    // ==========================================================
    // identifier fields
    localparam logic [2:0]  PRIO_WBP   = 3'h6;        // wheel pressure priority
    localparam logic [2:0]  PRIO_SUP   = 3'h6;        // supply pressure priority
    localparam logic [2:0]  PRIO_FUEL  = 3'h7;        // gaseous fuel priority
    localparam logic [2:0]  PRIO_HIST  = 3'h7;        // ecu history priority
    localparam logic        DATA_PAGE  = 1'b0;        // all groups on page zero
    localparam logic [7:0]  PF_GROUPS  = 8'hFE;       // pdu format 254
    localparam logic [7:0]  PS_WBP     = 8'hAD;       // pdu specific 173
    localparam logic [7:0]  PS_SUP     = 8'hAE;       // pdu specific 174
    localparam logic [7:0]  PS_FUEL    = 8'hAF;       // pdu specific 175
    localparam logic [7:0]  PS_HIST    = 8'hB1;       // pdu specific 177
    localparam logic [17:0] PGN_WBP    = 18'h0_FEAD;  // group 65197
    localparam logic [17:0] PGN_SUP    = 18'h0_FEAE;  // group 65198
    localparam logic [17:0] PGN_FUEL   = 18'h0_FEAF;  // group 65199
    localparam logic [17:0] PGN_HIST   = 18'h0_FEB1;  // group 65201
    localparam int unsigned PGN_DP_BIT = 16;          // data page bit of group number
    localparam int unsigned PGN_PF_LSB = 8;           // pdu format field
    localparam int unsigned PGN_PS_LSB = 0;           // pdu specific field
    localparam logic [3:0]  FRAME_LEN  = 4'h8;        // payload bytes

    // ==========================================================
    // payload layout and scaling
    localparam int unsigned BYTE_W          = 8;     // bits per payload byte
    localparam int unsigned WORD_LO_LSB     = 0;     // bytes 1..4
    localparam int unsigned WORD_HI_LSB     = 32;    // bytes 5..8
    localparam int unsigned WBP_CH          = 8;     // wheels in byte order
    localparam int unsigned SUP_CH          = 6;     // supply pressures
    localparam int unsigned WBP_KPA_W       = 11;    // kPa input width
    localparam int unsigned SUP_KPA_W       = 12;    // kPa input width
    localparam int unsigned WBP_KPA_PER_CNT = 5;     // 5 kPa per count
    localparam int unsigned SUP_KPA_PER_CNT = 8;     // 8 kPa per count
    localparam int unsigned WBP_MAX_KPA     = 1250;  // top of valid span
    localparam int unsigned SUP_MAX_KPA     = 2000;  // top of valid span
    localparam int unsigned CODE_VALID_MAX  = 250;   // highest valid byte code
    localparam logic [7:0]  BYTE_UNDEF      = 8'hFF; // not defined byte
    localparam logic [7:0]  BYTE_ERR        = 8'hFE; // out of range indicator

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        GRP_WBP  = 2'b00,
        GRP_SUP  = 2'b01,
        GRP_FUEL = 2'b10,
        GRP_HIST = 2'b11
    } vpc_group_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } vpc_state_e;

endpackage : vpc_pkg

// file: hw/vpc_press_if.sv
// vpc_press_if: pressure channels in kPa and their one-byte codes
// assumes one producer of kPa values and one converter
`timescale 1ns/1ps
interface vpc_press_if #(
    parameter int unsigned N = 8,
    parameter int unsigned W = 11
) ();
    logic [W-1:0] kpa  [N];   // pressure in kPa per channel
    logic [7:0]   code [N];   // scaled payload byte per channel

    modport src (output kpa, input code);
    modport cvt (input kpa, output code);
endinterface : vpc_press_if

// file: hw/vpc_press_scaler.sv
// vpc_press_scaler: kPa to one-byte code, per channel, combinational
// assumes kPa inputs stable for the cycle that the framer samples
`timescale 1ns/1ps
module vpc_press_scaler #(
    parameter int unsigned N       = 8,
    parameter int unsigned DIV     = 5,
    parameter int unsigned MAX_KPA = 1250
) (
    // channel carrier
    vpc_press_if.cvt prt
);

    // ==========================================================
    // parameter checks
    initial begin
        if (DIV == 0 || MAX_KPA / DIV > vpc_pkg::CODE_VALID_MAX) begin
            $error("vpc_press_scaler: span does not fit a byte");
        end
    end

    // ==========================================================
    // per channel scaling, zero offset
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_ch
            // out of span reads as the error indicator
            assign prt.code[gi] = (prt.kpa[gi] > MAX_KPA) ? vpc_pkg::BYTE_ERR :
                                  8'(prt.kpa[gi] / DIV);
        end
    endgenerate

endmodule : vpc_press_scaler

// file: hw/vpc_rate_timer.sv
// vpc_rate_timer: free running repetition tick, one pulse per period
// assumes sys_clk and synchronous active low rst_b
`timescale 1ns/1ps
module vpc_rate_timer #(
    parameter int unsigned PERIOD = 1000
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // tick out
    output logic      tick
);

    localparam int unsigned CW = $clog2(PERIOD + 1);   // counter width
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);  // terminal count

    initial begin
        if (PERIOD < 2) begin
            $error("vpc_rate_timer: period must be two cycles or more");
        end
    end

    logic [CW-1:0] cnt_reg;    // cycles into period
    logic [CW-1:0] cnt_next;   // next count

    // ==========================================================
    // next count, wraps at the end of the period
    always_comb begin
        cnt_next = (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end

    // register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // pulse on the last cycle of each period
    assign tick = (cnt_reg == LAST);

    // ticks never come back to back
    tick_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick |=> !tick) else $error("timer ticked twice in a row");

endmodule : vpc_rate_timer

// file: hw/vpc_codec.sv
// vpc_codec: builds and parses eight-byte payloads of four parameter groups
// assumes inputs from logic on sys_clk; frame transport is outside
// Operation
// - wheel pressure group identity, every 100 ms
// - wheel bytes ordered front, rear1, rear2, rear3
// - wheel byte 5 kPa per count
// - supply group identity, 1 s, bytes 1-2
// - supply bytes 3-6 scaled likewise, 7-8 undefined
// - supply byte 8 kPa per count
// - gaseous fuel group only on request
// - fuel trip then total, 0.5 kg counts
// - history group identity, distance in bytes 1-4
// - history run time in bytes 5-8
`timescale 1ns/1ps
module vpc_codec #(
    parameter int unsigned WBP_PERIOD_CYC = vpc_pkg::WBP_PERIOD_CYC,
    parameter int unsigned SUP_PERIOD_CYC = vpc_pkg::SUP_PERIOD_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // measured values to send
    input  wire logic [vpc_pkg::WBP_CH-1:0][vpc_pkg::WBP_KPA_W-1:0] wheel_kpa,
    input  wire logic [vpc_pkg::SUP_CH-1:0][vpc_pkg::SUP_KPA_W-1:0] supply_kpa,
    input  wire logic [31:0] trip_fuel_cnt,
    input  wire logic [31:0] total_fuel_cnt,
    input  wire logic [31:0] distance_cnt,
    input  wire logic [31:0] run_time_cnt,
    // on request triggers
    input  wire logic        req_fuel,
    input  wire logic        req_hist,
    // transmit frame
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [2:0]       tx_priority,
    output logic             tx_data_page,
    output logic [7:0]       tx_pdu_format,
    output logic [7:0]       tx_pdu_specific,
    output logic [17:0]      tx_pgn,
    output logic [3:0]       tx_len,
    output logic [63:0]      tx_payload,
    // receive frame
    input  wire logic        rx_valid,
    input  wire logic [17:0] rx_pgn,
    input  wire logic [63:0] rx_payload,
    // decoded values
    output logic [vpc_pkg::WBP_CH-1:0][vpc_pkg::WBP_KPA_W-1:0] rx_wheel_kpa,
    output logic             rx_wheel_valid,
    output logic [vpc_pkg::SUP_CH-1:0][vpc_pkg::SUP_KPA_W-1:0] rx_supply_kpa,
    output logic             rx_supply_valid,
    output logic [31:0]      rx_trip_fuel,
    output logic [31:0]      rx_total_fuel,
    output logic             rx_fuel_valid,
    output logic [31:0]      rx_distance,
    output logic [31:0]      rx_run_time,
    output logic             rx_hist_valid
);

    localparam int unsigned BW = vpc_pkg::BYTE_W;   // byte width

    // ==========================================================
    // pressure scaling
    vpc_press_if #(.N(vpc_pkg::WBP_CH), .W(vpc_pkg::WBP_KPA_W)) wbp_if ();
    vpc_press_if #(.N(vpc_pkg::SUP_CH), .W(vpc_pkg::SUP_KPA_W)) sup_if ();

    vpc_press_scaler #(
        .N       (vpc_pkg::WBP_CH),
        .DIV     (vpc_pkg::WBP_KPA_PER_CNT),
        .MAX_KPA (vpc_pkg::WBP_MAX_KPA)
    ) u_wbp_scale (
        .prt (wbp_if.cvt)
    );

    vpc_press_scaler #(
        .N       (vpc_pkg::SUP_CH),
        .DIV     (vpc_pkg::SUP_KPA_PER_CNT),
        .MAX_KPA (vpc_pkg::SUP_MAX_KPA)
    ) u_sup_scale (
        .prt (sup_if.cvt)
    );

    logic [63:0] wbp_word;   // wheel pressure payload
    logic [63:0] sup_word;   // supply pressure payload
    logic [vpc_pkg::WBP_CH-1:0][vpc_pkg::WBP_KPA_W-1:0] wbp_dec;   // rx wheel kPa
    logic [vpc_pkg::SUP_CH-1:0][vpc_pkg::SUP_KPA_W-1:0] sup_dec;   // rx supply kPa

    // per wheel: byte i is wheel i, front left first
    genvar gw;
    generate
        for (gw = 0; gw < vpc_pkg::WBP_CH; gw++) begin : g_wbp
            assign wbp_if.kpa[gw]         = wheel_kpa[gw];
            assign wbp_word[gw*BW +: BW]  = wbp_if.code[gw];
            assign wbp_dec[gw] = vpc_pkg::WBP_KPA_W'(rx_payload[gw*BW +: BW]
                                 * vpc_pkg::WBP_KPA_PER_CNT);
        end
    endgenerate

    // per supply channel, then undefined fill above
    genvar gs;
    generate
        for (gs = 0; gs < vpc_pkg::SUP_CH; gs++) begin : g_sup
            assign sup_if.kpa[gs]        = supply_kpa[gs];
            assign sup_word[gs*BW +: BW] = sup_if.code[gs];
            assign sup_dec[gs] = vpc_pkg::SUP_KPA_W'(rx_payload[gs*BW +: BW]
                                 * vpc_pkg::SUP_KPA_PER_CNT);
        end
    endgenerate
    // bytes 7 and 8 carry all ones
    assign sup_word[63:vpc_pkg::SUP_CH*BW] = {vpc_pkg::BYTE_UNDEF, vpc_pkg::BYTE_UNDEF};

    // ==========================================================
    // repetition timers
    logic wbp_tick;   // 100 ms pulse
    logic sup_tick;   // 1 s pulse

    vpc_rate_timer #(.PERIOD(WBP_PERIOD_CYC)) u_wbp_tmr (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (wbp_tick)
    );

    vpc_rate_timer #(.PERIOD(SUP_PERIOD_CYC)) u_sup_tmr (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tick    (sup_tick)
    );

    // ==========================================================
    // transmit scheduler
    vpc_pkg::vpc_state_e st_reg,   st_next;     // launch state
    logic [3:0]          pend_reg, pend_next;   // groups waiting, one bit each
    logic [2:0]          prio_reg, prio_next;   // latched priority
    logic [17:0]         pgn_reg,  pgn_next;    // latched group number
    logic [63:0]         pay_reg,  pay_next;    // latched payload
    vpc_pkg::vpc_group_e pick;                  // highest waiting group
    logic [3:0]          set_v;                 // new demands
    logic [3:0]          clr_v;                 // group launched now
    logic                launch;                // frame loaded this cycle

    // fixed order: wheel, supply, fuel, history
    always_comb begin
        if (pend_reg[vpc_pkg::GRP_WBP]) begin
            pick = vpc_pkg::GRP_WBP;
        end else if (pend_reg[vpc_pkg::GRP_SUP]) begin
            pick = vpc_pkg::GRP_SUP;
        end else if (pend_reg[vpc_pkg::GRP_FUEL]) begin
            pick = vpc_pkg::GRP_FUEL;
        end else begin
            pick = vpc_pkg::GRP_HIST;
        end
    end

    // next state, waiting set and frame contents
    always_comb begin
        st_next   = st_reg;
        prio_next = prio_reg;
        pgn_next  = pgn_reg;
        pay_next  = pay_reg;
        launch    = 1'b0;
        clr_v     = '0;
        // periodic groups by timer, fuel and history only on request
        set_v = {req_hist, req_fuel, sup_tick, wbp_tick};
        case (st_reg)
            vpc_pkg::ST_IDLE: begin
                if (pend_reg != '0) begin
                    launch       = 1'b1;
                    clr_v[pick]  = 1'b1;
                    st_next      = vpc_pkg::ST_SEND;
                    case (pick)
                        vpc_pkg::GRP_WBP: begin
                            prio_next = vpc_pkg::PRIO_WBP;
                            pgn_next  = vpc_pkg::PGN_WBP;
                            pay_next  = wbp_word;
                        end
                        vpc_pkg::GRP_SUP: begin
                            prio_next = vpc_pkg::PRIO_SUP;
                            pgn_next  = vpc_pkg::PGN_SUP;
                            pay_next  = sup_word;
                        end
                        vpc_pkg::GRP_FUEL: begin
                            prio_next = vpc_pkg::PRIO_FUEL;
                            pgn_next  = vpc_pkg::PGN_FUEL;
                            pay_next  = {total_fuel_cnt, trip_fuel_cnt};
                        end
                        default: begin
                            prio_next = vpc_pkg::PRIO_HIST;
                            pgn_next  = vpc_pkg::PGN_HIST;
                            pay_next  = {run_time_cnt, distance_cnt};
                        end
                    endcase
                end
            end
            vpc_pkg::ST_SEND: begin
                // hold the frame until the transport takes it
                if (tx_ready) begin
                    st_next = vpc_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next = vpc_pkg::ST_IDLE;
            end
        endcase
        // a demand in the launch cycle stays waiting
        pend_next = (pend_reg & ~clr_v) | set_v;
    end

    // register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_reg   <= vpc_pkg::ST_IDLE;
            pend_reg <= '0;
            prio_reg <= '0;
            pgn_reg  <= '0;
            pay_reg  <= '0;
        end else begin
            st_reg   <= st_next;
            pend_reg <= pend_next;
            prio_reg <= prio_next;
            pgn_reg  <= pgn_next;
            pay_reg  <= pay_next;
        end
    end

    // frame outputs straight from the latched fields, length fixed at FRAME_LEN
    assign tx_valid        = (st_reg == vpc_pkg::ST_SEND);
    assign tx_priority     = prio_reg;
    assign tx_pgn          = pgn_reg;
    assign tx_data_page    = pgn_reg[vpc_pkg::PGN_DP_BIT];
    assign tx_pdu_format   = pgn_reg[vpc_pkg::PGN_PF_LSB +: BW];
    assign tx_pdu_specific = pgn_reg[vpc_pkg::PGN_PS_LSB +: BW];
    assign tx_len          = vpc_pkg::FRAME_LEN;
    assign tx_payload      = pay_reg;

    // ==========================================================
    // receive parser
    logic [vpc_pkg::WBP_CH-1:0][vpc_pkg::WBP_KPA_W-1:0] rwb_reg, rwb_next;   // wheels
    logic [vpc_pkg::SUP_CH-1:0][vpc_pkg::SUP_KPA_W-1:0] rsp_reg, rsp_next;   // supplies
    logic [31:0] rtf_reg, rtf_next;    // trip fuel
    logic [31:0] rto_reg, rto_next;    // total fuel
    logic [31:0] rds_reg, rds_next;    // distance
    logic [31:0] rrt_reg, rrt_next;    // run time
    logic [3:0]  rstb_reg, rstb_next;  // per group update pulses

    // decode by group number, bytes 7-8 of supply are never read
    always_comb begin
        rwb_next  = rwb_reg;
        rsp_next  = rsp_reg;
        rtf_next  = rtf_reg;
        rto_next  = rto_reg;
        rds_next  = rds_reg;
        rrt_next  = rrt_reg;
        rstb_next = '0;
        if (rx_valid) begin
            case (rx_pgn)
                vpc_pkg::PGN_WBP: begin
                    rwb_next                   = wbp_dec;
                    rstb_next[vpc_pkg::GRP_WBP] = 1'b1;
                end
                vpc_pkg::PGN_SUP: begin
                    rsp_next                   = sup_dec;
                    rstb_next[vpc_pkg::GRP_SUP] = 1'b1;
                end
                vpc_pkg::PGN_FUEL: begin
                    rtf_next = rx_payload[vpc_pkg::WORD_LO_LSB +: 32];
                    rto_next = rx_payload[vpc_pkg::WORD_HI_LSB +: 32];
                    rstb_next[vpc_pkg::GRP_FUEL] = 1'b1;
                end
                vpc_pkg::PGN_HIST: begin
                    rds_next = rx_payload[vpc_pkg::WORD_LO_LSB +: 32];
                    rrt_next = rx_payload[vpc_pkg::WORD_HI_LSB +: 32];
                    rstb_next[vpc_pkg::GRP_HIST] = 1'b1;
                end
                default: begin
                    rstb_next = '0;
                end
            endcase
        end
    end

    // register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rwb_reg  <= '0;
            rsp_reg  <= '0;
            rtf_reg  <= '0;
            rto_reg  <= '0;
            rds_reg  <= '0;
            rrt_reg  <= '0;
            rstb_reg <= '0;
        end else begin
            rwb_reg  <= rwb_next;
            rsp_reg  <= rsp_next;
            rtf_reg  <= rtf_next;
            rto_reg  <= rto_next;
            rds_reg  <= rds_next;
            rrt_reg  <= rrt_next;
            rstb_reg <= rstb_next;
        end
    end

    assign rx_wheel_kpa    = rwb_reg;
    assign rx_supply_kpa   = rsp_reg;
    assign rx_trip_fuel    = rtf_reg;
    assign rx_total_fuel   = rto_reg;
    assign rx_distance     = rds_reg;
    assign rx_run_time     = rrt_reg;
    assign rx_wheel_valid  = rstb_reg[vpc_pkg::GRP_WBP];
    assign rx_supply_valid = rstb_reg[vpc_pkg::GRP_SUP];
    assign rx_fuel_valid   = rstb_reg[vpc_pkg::GRP_FUEL];
    assign rx_hist_valid   = rstb_reg[vpc_pkg::GRP_HIST];

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence launch_s(vpc_pkg::vpc_group_e g);
        launch && (pick == g);
    endsequence

    sequence sent_s(logic [17:0] p);
        tx_valid && (tx_pgn == p);
    endsequence

    wbp_ident_a: assert property (sent_s(vpc_pkg::PGN_WBP) |->
        tx_priority == vpc_pkg::PRIO_WBP && !tx_data_page
        && tx_pdu_format == vpc_pkg::PF_GROUPS && tx_pdu_specific == vpc_pkg::PS_WBP)
        else $error("wheel pressure identity wrong");
    wbp_period_a: assert property (wbp_tick |=> pend_reg[vpc_pkg::GRP_WBP])
        else $error("wheel pressure tick lost");
    wbp_order_a: assert property (launch_s(vpc_pkg::GRP_WBP) |=>
        tx_payload[BW-1:0] == $past(wbp_if.code[0])
        && tx_payload[63:56] == $past(wbp_if.code[vpc_pkg::WBP_CH-1]))
        else $error("wheel byte order wrong");
    wbp_scale_a: assert property (launch_s(vpc_pkg::GRP_WBP) ##0
        (wheel_kpa[0] <= vpc_pkg::WBP_MAX_KPA) |=>
        tx_payload[BW-1:0] == 8'($past(wheel_kpa[0]) / vpc_pkg::WBP_KPA_PER_CNT))
        else $error("wheel scaling wrong");
    sup_ident_a: assert property (sent_s(vpc_pkg::PGN_SUP) |->
        tx_priority == vpc_pkg::PRIO_SUP && tx_pdu_specific == vpc_pkg::PS_SUP)
        else $error("supply identity wrong");
    sup_fill_a: assert property (launch_s(vpc_pkg::GRP_SUP) |=>
        tx_payload[63:48] == {vpc_pkg::BYTE_UNDEF, vpc_pkg::BYTE_UNDEF}
        && tx_payload[47:40] == $past(sup_if.code[vpc_pkg::SUP_CH-1]))
        else $error("supply layout wrong");
    sup_scale_a: assert property (launch_s(vpc_pkg::GRP_SUP) ##0
        (supply_kpa[0] > vpc_pkg::SUP_MAX_KPA) |=> tx_payload[BW-1:0] == vpc_pkg::BYTE_ERR)
        else $error("supply range flag wrong");
    fuel_req_a: assert property ($rose(pend_reg[vpc_pkg::GRP_FUEL]) |-> $past(req_fuel))
        else $error("fuel group without request");
    fuel_word_a: assert property (launch_s(vpc_pkg::GRP_FUEL) |=>
        tx_payload == {$past(total_fuel_cnt), $past(trip_fuel_cnt)})
        else $error("fuel payload wrong");
    hist_ident_a: assert property (sent_s(vpc_pkg::PGN_HIST) |->
        tx_priority == vpc_pkg::PRIO_HIST && tx_pdu_specific == vpc_pkg::PS_HIST)
        else $error("history identity wrong");
    hist_time_a: assert property (launch_s(vpc_pkg::GRP_HIST) |=>
        tx_payload[63:32] == $past(run_time_cnt))
        else $error("history run time misplaced");
    rx_lsb_first_a: assert property (rx_valid && rx_pgn == vpc_pkg::PGN_HIST |=>
        rx_hist_valid && rx_distance[BW-1:0] == $past(rx_payload[BW-1:0]))
        else $error("history parse wrong");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_payload))
        else $error("frame dropped before accept");

endmodule : vpc_codec

// file: tb/vpc_peer.sv
// vpc_peer: transport side that takes the frames the codec offers
// assumes tx_valid comes from the codec on sys_clk
`timescale 1ns/1ps
module vpc_peer (
    // clock, reset and pace
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic slow,
    // frame handshake
    input  wire logic tx_valid,
    output logic      tx_ready
);
    logic [1:0] wait_reg; // cycles the frame has waited
    // count waiting cycles; slow pace stalls each frame 3 cycles
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !tx_valid) wait_reg <= 2'h0;
        else wait_reg <= wait_reg + 2'h1;
    end
    assign tx_ready = tx_valid && (!slow || wait_reg == 2'h3);
endmodule : vpc_peer

// file: tb/tb_vpc_codec.sv
// tb_vpc_codec: self-checking bench of the payload codec
// assumes short repeat periods; peer model on the transmit side
`timescale 1ns/1ps
module tb_vpc_codec;
    logic sys_clk = 0, rst_b = 0, slow = 0, tx_ready;
    logic req_fuel = 0, req_hist = 0, rx_valid = 0, tx_valid, tx_data_page;
    logic [vpc_pkg::WBP_CH-1:0][vpc_pkg::WBP_KPA_W-1:0] wheel_kpa, rx_wheel_kpa;
    logic [vpc_pkg::SUP_CH-1:0][vpc_pkg::SUP_KPA_W-1:0] supply_kpa, rx_supply_kpa;
    logic [31:0] trip_fuel_cnt = 32'h1234_5678, total_fuel_cnt = 32'h9ABC_DEF0;
    logic [31:0] distance_cnt = 32'h0102_0304, run_time_cnt = 32'hA0B0_C0D0;
    logic [31:0] rx_trip_fuel, rx_total_fuel, rx_distance, rx_run_time;
    logic rx_wheel_valid, rx_supply_valid, rx_fuel_valid, rx_hist_valid;
    logic [2:0] tx_priority;
    logic [7:0] tx_pdu_format, tx_pdu_specific;
    logic [17:0] tx_pgn, rx_pgn = 18'h0_0000;
    logic [3:0] tx_len;
    logic [63:0] tx_payload, rx_payload = 64'h0807_0605_0403_0201;
    int errors = 0, total_checks = 0;
    localparam int WV[8] = '{0, 5, 7, 1249, 1250, 1251, 600, 2047};
    localparam int SV[6] = '{0, 8, 15, 2000, 2001, 4095};
    always #50 sys_clk = ~sys_clk;
    vpc_peer peer (.sys_clk, .rst_b, .slow, .tx_valid, .tx_ready);
    vpc_codec #(.WBP_PERIOD_CYC(200), .SUP_PERIOD_CYC(500)) dut (
        .sys_clk, .rst_b, .wheel_kpa, .supply_kpa, .trip_fuel_cnt,
        .total_fuel_cnt, .distance_cnt, .run_time_cnt, .req_fuel, .req_hist,
        .tx_valid, .tx_ready, .tx_priority, .tx_data_page, .tx_pdu_format,
        .tx_pdu_specific, .tx_pgn, .tx_len, .tx_payload, .rx_valid, .rx_pgn,
        .rx_payload, .rx_wheel_kpa, .rx_wheel_valid, .rx_supply_kpa,
        .rx_supply_valid, .rx_trip_fuel, .rx_total_fuel, .rx_fuel_valid,
        .rx_distance, .rx_run_time, .rx_hist_valid);
    // compare and count
    task automatic ck(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %0t value %h expected %h", $time, g, e);
        end
    endtask : ck
    // wait for an accepted frame of one group, then judge it
    task automatic get(input logic [17:0] p, input logic [2:0] pr, input logic [63:0] e);
        int n;
        for (n = 0; n < 3000; n++) begin
            @(negedge sys_clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_pgn === p) break;
        end
        if (n == 3000) begin
            errors++;
            $display("Error %0t frame never came", $time);
            results();
        end else begin
            ck(tx_payload, e);
            ck({tx_priority, tx_data_page, tx_pdu_format, tx_pdu_specific, tx_len},
               {pr, p[16:0], 4'h8});
        end
    endtask : get
    // periodic groups: scaling, byte order, out of range, filler
    task automatic t_tx;
        logic [63:0] e, s;
        s = 64'hFFFF_FFFF_FFFF_FFFF;
        for (int i = 0; i < 8; i++) e[8*i+:8] = WV[i] > 1250 ? 8'hFE : 8'(WV[i] / 5);
        for (int i = 0; i < 6; i++) s[8*i+:8] = SV[i] > 2000 ? 8'hFE : 8'(SV[i] / 8);
        get(18'h0_FEAD, 3'h6, e);
        get(18'h0_FEAE, 3'h6, s);
    endtask : t_tx
    // both requests in one cycle with a stalling peer
    task automatic t_req;
        slow = 1;
        req_fuel = 1;
        req_hist = 1;
        @(negedge sys_clk);
        req_fuel = 0;
        req_hist = 0;
        get(18'h0_FEAF, 3'h7, {total_fuel_cnt, trip_fuel_cnt});
        get(18'h0_FEB1, 3'h7, {run_time_cnt, distance_cnt});
        slow = 0;
    endtask : t_req
    // one received frame, judged one cycle later
    task automatic rx(input logic [17:0] p);
        @(negedge sys_clk);
        rx_pgn = p;
        rx_valid = 1;
        @(negedge sys_clk);
        rx_valid = 0;
    endtask : rx
    task automatic t_rx;
        rx(18'h0_FEAD);
        ck(rx_wheel_valid, 1);
        for (int i = 0; i < 8; i++) ck(rx_wheel_kpa[i], (i + 1) * 5);
        rx(18'h0_FEB1);
        ck(rx_hist_valid, 1);
        ck({rx_run_time, rx_distance}, rx_payload);
        rx(18'h0_FEAF);
        ck(rx_fuel_valid, 1);
        ck({rx_total_fuel, rx_trip_fuel}, rx_payload);
        rx(18'h0_FEAE);
        ck(rx_supply_valid, 1);
        for (int i = 0; i < 6; i++) ck(rx_supply_kpa[i], (i + 1) * 8);
        rx(18'h0_FEB0);
        ck({rx_wheel_valid, rx_supply_valid, rx_fuel_valid, rx_hist_valid}, 0);
    endtask : t_rx
    task automatic results;
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        for (int i = 0; i < 8; i++) wheel_kpa[i] = 11'(WV[i]);
        for (int i = 0; i < 6; i++) supply_kpa[i] = 12'(SV[i]);
        repeat (8) @(negedge sys_clk);
        rst_b = 1;
        t_tx();
        t_req();
        t_rx();
        results();
    end
endmodule : tb_vpc_codec
